// ===== ifd_pkg.sv
// Constants, field layouts and carrier types of the instruction format decoder.
// Assumes a 16-bit instruction word and a 21-bit byte program counter.
package ifd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int OPC_HI    = 15;
    localparam int OPC_LO    = 10;
    localparam int DEST_BIT  = 9;
    localparam int ACC_BIT   = 8;
    localparam int FADDR_HI  = 7;
    localparam int BITPOS_HI = 11;
    localparam int BITPOS_LO = 9;
    localparam int LONG_HI   = 11;
    localparam int TAG_HI    = 15;
    localparam int TAG_LO    = 12;
    localparam int UPPER_LO  = 8;
    localparam int FAST_BIT  = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Opcode patterns
    localparam logic [3:0] SECOND_TAG   = 4'hf;
    localparam logic [3:0] MOVE_NIB     = 4'hc;
    localparam logic [3:0] BIT_NIB_LO   = 4'h7;
    localparam logic [3:0] BIT_NIB_HI   = 4'hb;
    localparam logic [4:0] LIT_HI5      = 5'h01;
    localparam logic [6:0] CALL_HI7     = 7'h76;
    localparam logic [7:0] GOTO_OPC     = 8'hef;
    localparam logic [7:0] BRZ_OPC      = 8'he0;

    ////////////////////////////////////////////////////////////////////////////
    // Access bank split and reset values
    localparam logic [7:0]  ACCESS_SPLIT = 8'h60;
    localparam logic [3:0]  ACCESS_LOW   = 4'h0;
    localparam logic [3:0]  ACCESS_HIGH  = 4'hf;
    localparam logic [20:0] PC_STEP      = 21'h0_0002;
    localparam logic [20:0] PC_RESET     = 21'h0_0000;
    localparam logic [15:0] WORD_RESET   = 16'h0000;

    typedef enum logic [3:0] {
        FMT_NONE = 4'h0,
        FMT_BYTE = 4'h1,
        FMT_BIT  = 4'h2,
        FMT_LIT  = 4'h3,
        FMT_MOVE = 4'h4,
        FMT_CALL = 4'h5,
        FMT_GOTO = 4'h6,
        FMT_BRZ  = 4'h7
    } ifd_format_type;

    typedef enum logic [2:0] {
        ST_FETCH  = 3'b001,
        ST_SECOND = 3'b010,
        ST_FLUSH  = 3'b100
    } ifd_state_type;

    // Fields of one instruction word
    typedef struct packed {
        ifd_format_type format;
        logic [5:0]     opcode;
        logic           write_file;
        logic [11:0]    data_addr;
        logic [2:0]     bit_pos;
        logic [7:0]     literal;
        logic           fast_return;
    } ifd_fields_type;

    // Decoded result handed to the datapath
    typedef struct packed {
        logic           valid;
        ifd_format_type format;
        logic [5:0]     opcode;
        logic           write_file;
        logic           write_working;
        logic [11:0]    data_addr;
        logic [2:0]     bit_pos;
        logic [7:0]     literal;
        logic           fast_return;
        logic [11:0]    move_src;
        logic [11:0]    move_dst;
        logic [20:0]    target;
        logic           bad_second;
    } ifd_decode_type;

endpackage

// ===== ifd_field_split.sv
// Combinational split of one instruction word into its format fields.
// Assumes the bank selection register value is stable with the word.
`timescale 1ns/1ps
module ifd_field_split (
    input  wire logic [15:0]            word,
    input  wire logic [3:0]             bank_select,
    output ifd_pkg::ifd_fields_type     fields
);

    ////////////////////////////////////////////////////////////////////////////
    // Shared by byte and bit formats
    function automatic logic [11:0] full_addr(input logic acc, input logic [7:0] f,
                                              input logic [3:0] bank_selection_register);
        logic [3:0] bank;
        bank = bank_selection_register;
        if (!acc) begin
            bank = (f < ifd_pkg::ACCESS_SPLIT) ? ifd_pkg::ACCESS_LOW : ifd_pkg::ACCESS_HIGH;
        end
        return {bank, f};
    endfunction

    logic [3:0] nib;
    assign nib = word[ifd_pkg::TAG_HI:ifd_pkg::TAG_LO];

    always_comb begin
        fields             = '0;
        fields.opcode      = word[ifd_pkg::OPC_HI:ifd_pkg::OPC_LO];
        fields.write_file  = word[ifd_pkg::DEST_BIT];
        fields.data_addr   = full_addr(word[ifd_pkg::ACC_BIT], word[ifd_pkg::FADDR_HI:0],
                                       bank_select);
        fields.bit_pos     = word[ifd_pkg::BITPOS_HI:ifd_pkg::BITPOS_LO];
        fields.literal     = word[ifd_pkg::FADDR_HI:0];
        fields.fast_return = word[ifd_pkg::FAST_BIT];
        if (nib == ifd_pkg::MOVE_NIB) begin
            fields.format = ifd_pkg::FMT_MOVE;
        end else if (nib >= ifd_pkg::BIT_NIB_LO && nib <= ifd_pkg::BIT_NIB_HI) begin
            fields.format = ifd_pkg::FMT_BIT;
        end else if (word[15:8] == ifd_pkg::BRZ_OPC) begin
            fields.format = ifd_pkg::FMT_BRZ;
        end else if (word[15:9] == ifd_pkg::CALL_HI7) begin
            fields.format = ifd_pkg::FMT_CALL;
        end else if (word[15:8] == ifd_pkg::GOTO_OPC) begin
            fields.format = ifd_pkg::FMT_GOTO;
        end else if (word[15:11] == ifd_pkg::LIT_HI5) begin
            fields.format = ifd_pkg::FMT_LIT;
        end else if (nib != ifd_pkg::SECOND_TAG && nib != 4'he && nib != 4'hd) begin
            fields.format = ifd_pkg::FMT_BYTE;
        end else begin
            fields.format = ifd_pkg::FMT_NONE;
        end
    end

endmodule

// ===== ifd_branch_unit.sv
// Condition test and relative target of the branch-on-zero instruction.
// Assumes the program counter given is the address of the branch itself.
`timescale 1ns/1ps
module ifd_branch_unit (
    input  wire logic [20:0] pc,
    input  wire logic [7:0]  offset,
    input  wire logic        zero_flag,
    output logic             taken,
    output logic [20:0]      target
);

    logic [20:0] twice;

    assign twice  = {{12{offset[7]}}, offset, 1'b0};
    assign target = 21'(pc + ifd_pkg::PC_STEP + twice);
    assign taken  = zero_flag;

endmodule

// ===== ifd_decoder.sv
// Top of the instruction format decoder: accepts words, registers decode results.
// Assumes the fetch path holds a word while instr_ready is low.
`timescale 1ns/1ps
module ifd_decoder (
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    input  wire logic               instr_valid,
    input  wire logic [15:0]        instr_word,
    input  wire logic [20:0]        instr_pc,
    input  wire logic               zero_flag,
    input  wire logic [3:0]         bank_select,
    output logic                    instr_ready,
    output ifd_pkg::ifd_decode_type dec,
    output logic                    pc_load,
    output logic [20:0]             pc_value,
    output logic                    nop_cycle
);

    ////////////////////////////////////////////////////////////////////////////
    // Leaves
    ifd_pkg::ifd_fields_type fld;
    logic                    br_taken;
    logic [20:0]             br_target;

    ifd_field_split u_split (
        .word        (instr_word),
        .bank_select (bank_select),
        .fields      (fld)
    );

    ifd_branch_unit u_branch (
        .pc        (instr_pc),
        .offset    (instr_word[7:0]),
        .zero_flag (zero_flag),
        .taken     (br_taken),
        .target    (br_target)
    );

    ////////////////////////////////////////////////////////////////////////////
    // State
    ifd_pkg::ifd_state_type  state;
    ifd_pkg::ifd_state_type  next_state;
    logic [15:0]             first_word;
    logic [15:0]             next_first_word;
    ifd_pkg::ifd_decode_type next_dec;
    logic                    next_pc_load;
    logic [20:0]             next_pc_value;
    logic                    next_nop_cycle;
    logic                    next_instr_ready;
    logic                    take_first;
    logic                    take_second;

    assign take_first  = instr_valid && state == ifd_pkg::ST_FETCH;
    assign take_second = instr_valid && state == ifd_pkg::ST_SECOND;

    always_comb begin
        next_state       = state;
        next_first_word  = first_word;
        next_dec         = dec;
        next_dec.valid   = 1'b0;
        next_pc_load     = 1'b0;
        next_pc_value    = pc_value;
        next_nop_cycle   = 1'b0;
        unique case (state)
            ifd_pkg::ST_FETCH: begin
                if (instr_valid) begin
                    next_dec.format        = fld.format;
                    next_dec.opcode        = fld.opcode;
                    next_dec.write_file    = fld.write_file;
                    next_dec.write_working = !fld.write_file;
                    next_dec.data_addr     = fld.data_addr;
                    next_dec.bit_pos       = fld.bit_pos;
                    next_dec.literal       = fld.literal;
                    next_dec.fast_return   = 1'b0;
                    next_dec.bad_second    = 1'b0;
                    next_dec.move_src      = '0;
                    next_dec.move_dst      = '0;
                    next_dec.target        = '0;
                    unique case (fld.format)
                        ifd_pkg::FMT_MOVE, ifd_pkg::FMT_CALL, ifd_pkg::FMT_GOTO: begin
                            next_first_word = instr_word;
                            next_state      = ifd_pkg::ST_SECOND;
                        end
                        ifd_pkg::FMT_BRZ: begin
                            next_dec.valid  = 1'b1;
                            next_dec.target = br_target;
                            if (br_taken) begin
                                next_pc_load   = 1'b1;
                                next_pc_value  = br_target;
                                next_nop_cycle = 1'b1;
                                next_state     = ifd_pkg::ST_FLUSH;
                            end
                        end
                        default: begin
                            next_dec.valid = 1'b1;
                        end
                    endcase
                end
            end
            ifd_pkg::ST_SECOND: begin
                if (instr_valid) begin
                    next_state     = ifd_pkg::ST_FETCH;
                    next_dec.valid = 1'b1;
                    if (instr_word[ifd_pkg::TAG_HI:ifd_pkg::TAG_LO] != ifd_pkg::SECOND_TAG) begin
                        // Untagged second word: report, never load PC
                        next_dec.bad_second = 1'b1;
                    end else if (next_dec.format == ifd_pkg::FMT_MOVE) begin
                        next_dec.move_src = first_word[ifd_pkg::LONG_HI:0];
                        next_dec.move_dst = instr_word[ifd_pkg::LONG_HI:0];
                    end else begin
                        next_dec.target = {instr_word[ifd_pkg::LONG_HI:0],
                                           first_word[ifd_pkg::FADDR_HI:0], 1'b0};
                        next_dec.fast_return = (dec.format == ifd_pkg::FMT_CALL) &&
                                               first_word[ifd_pkg::FAST_BIT];
                        next_pc_load  = 1'b1;
                        next_pc_value = {instr_word[ifd_pkg::LONG_HI:0],
                                         first_word[ifd_pkg::FADDR_HI:0], 1'b0};
                    end
                end
            end
            ifd_pkg::ST_FLUSH: begin
                // Stale word fetched behind the branch is dropped
                next_state = ifd_pkg::ST_FETCH;
            end
            default: begin
                next_state = ifd_pkg::ST_FETCH;
            end
        endcase
        next_instr_ready = next_state != ifd_pkg::ST_FLUSH;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state       <= ifd_pkg::ST_FETCH;
            first_word  <= ifd_pkg::WORD_RESET;
            dec         <= '0;
            pc_load     <= 1'b0;
            pc_value    <= ifd_pkg::PC_RESET;
            nop_cycle   <= 1'b0;
            instr_ready <= 1'b1;
        end else begin
            state       <= next_state;
            first_word  <= next_first_word;
            dec         <= next_dec;
            pc_load     <= next_pc_load;
            pc_value    <= next_pc_value;
            nop_cycle   <= next_nop_cycle;
            instr_ready <= next_instr_ready;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence seq_byte_taken;
        take_first && fld.format == ifd_pkg::FMT_BYTE;
    endsequence

    sequence seq_move_pair;
        take_first && fld.format == ifd_pkg::FMT_MOVE ##1
        take_second && instr_word[15:12] == ifd_pkg::SECOND_TAG;
    endsequence

    sequence seq_jump_pair;
        take_first && fld.format == ifd_pkg::FMT_GOTO ##1
        take_second && instr_word[15:12] == ifd_pkg::SECOND_TAG;
    endsequence

    sequence seq_call_pair;
        take_first && fld.format == ifd_pkg::FMT_CALL ##1
        take_second && instr_word[15:12] == ifd_pkg::SECOND_TAG;
    endsequence

    sequence seq_brz_taken;
        take_first && fld.format == ifd_pkg::FMT_BRZ && zero_flag;
    endsequence

    AST_BYTE_FIELDS: assert property (@(posedge core_clk) disable iff (!rst_n)
        seq_byte_taken |=> dec.valid && dec.opcode == $past(instr_word[15:10])
        && dec.data_addr[7:0] == $past(instr_word[7:0]))
        else $error("byte op fields wrong");

    AST_DEST_SELECT: assert property (@(posedge core_clk) disable iff (!rst_n)
        seq_byte_taken |=> dec.write_file == $past(instr_word[9])
        && dec.write_working != dec.write_file)
        else $error("destination select wrong");

    AST_BANK_SOURCE: assert property (@(posedge core_clk) disable iff (!rst_n)
        seq_byte_taken ##0 instr_word[8] |=> dec.data_addr[11:8] == $past(bank_select))
        else $error("bank not from bank register");

    AST_ACCESS_FORCE: assert property (@(posedge core_clk) disable iff (!rst_n)
        seq_byte_taken ##0 !instr_word[8] |=>
        dec.data_addr[11:8] == ($past(instr_word[7:0]) < 8'h60 ? 4'h0 : 4'hf))
        else $error("access bank not forced");

    AST_MOVE_ADDR: assert property (@(posedge core_clk) disable iff (!rst_n)
        seq_move_pair |=> dec.valid && dec.move_dst == $past(instr_word[11:0])
        && dec.move_src == $past(instr_word[11:0], 2))
        else $error("move addresses wrong");

    AST_BIT_POS: assert property (@(posedge core_clk) disable iff (!rst_n)
        take_first && fld.format == ifd_pkg::FMT_BIT |=>
        dec.bit_pos == $past(instr_word[11:9]) && dec.data_addr[7:0] == $past(instr_word[7:0]))
        else $error("bit position wrong");

    AST_LITERAL: assert property (@(posedge core_clk) disable iff (!rst_n)
        take_first && fld.format == ifd_pkg::FMT_LIT |=> dec.valid
        && dec.literal == $past(instr_word[7:0]))
        else $error("literal wrong");

    AST_GOTO_TARGET: assert property (@(posedge core_clk) disable iff (!rst_n)
        seq_jump_pair |=> pc_load && pc_value == {$past(instr_word[11:0]),
        $past(instr_word[7:0], 2), 1'b0})
        else $error("goto target wrong");

    AST_CALL_FAST: assert property (@(posedge core_clk) disable iff (!rst_n)
        seq_call_pair |=> dec.fast_return == $past(instr_word[8], 2))
        else $error("fast return bit lost");

    AST_BRZ_NOT_TAKEN: assert property (@(posedge core_clk) disable iff (!rst_n)
        take_first && fld.format == ifd_pkg::FMT_BRZ && !zero_flag |=>
        !pc_load && !nop_cycle && instr_ready)
        else $error("branch taken without zero");

    AST_BRZ_TARGET: assert property (@(posedge core_clk) disable iff (!rst_n)
        seq_brz_taken |=> pc_load && pc_value == 21'($past(instr_pc) + 21'h0_0002
        + {{12{$past(instr_word[7])}}, $past(instr_word[7:0]), 1'b0}))
        else $error("branch target wrong");

    AST_BRZ_OPCODE: assert property (@(posedge core_clk) disable iff (!rst_n)
        take_first && instr_word[15:8] == 8'he0 |=> dec.format == ifd_pkg::FMT_BRZ)
        else $error("branch opcode not recognised");

    AST_BRZ_CYCLES: assert property (@(posedge core_clk) disable iff (!rst_n)
        seq_brz_taken |=> nop_cycle && !instr_ready ##1 !nop_cycle && instr_ready)
        else $error("taken branch cycle count wrong");

    ////////////////////////////////////////////////////////////////////////////
    // Second words, bit banks and the no-op cycle
    sequence seq_untagged_second;
        take_second && instr_word[15:12] != ifd_pkg::SECOND_TAG;
    endsequence

    sequence seq_bit_banked;
        take_first && fld.format == ifd_pkg::FMT_BIT && instr_word[8];
    endsequence

    AST_CALL_TARGET: assert property (@(posedge core_clk) disable iff (!rst_n)
        seq_call_pair |=> pc_load && dec.valid && pc_value == {$past(instr_word[11:0]),
        $past(instr_word[7:0], 2), 1'b0})
        else $error("call target wrong");

    AST_BAD_SECOND: assert property (@(posedge core_clk) disable iff (!rst_n)
        seq_untagged_second |=> dec.valid && dec.bad_second && !pc_load)
        else $error("untagged second word accepted");

    AST_TWO_WORD_WAIT: assert property (@(posedge core_clk) disable iff (!rst_n)
        state == ifd_pkg::ST_SECOND && !instr_valid |=> !dec.valid && !pc_load)
        else $error("two-word result without second word");

    AST_MOVE_NO_LOAD: assert property (@(posedge core_clk) disable iff (!rst_n)
        seq_move_pair |=> !pc_load && !dec.bad_second && dec.format == ifd_pkg::FMT_MOVE)
        else $error("move loaded the program counter");

    AST_GOTO_NO_FAST: assert property (@(posedge core_clk) disable iff (!rst_n)
        seq_jump_pair |=> !dec.fast_return)
        else $error("fast return set on goto");

    AST_BIT_BANK: assert property (@(posedge core_clk) disable iff (!rst_n)
        seq_bit_banked |=> dec.data_addr[11:8] == $past(bank_select))
        else $error("bit op bank wrong");

    AST_BIT_ACCESS: assert property (@(posedge core_clk) disable iff (!rst_n)
        take_first && fld.format == ifd_pkg::FMT_BIT && !instr_word[8] |=>
        dec.data_addr[11:8] == ($past(instr_word[7:0]) < 8'h60 ? 4'h0 : 4'hf))
        else $error("bit op access bank wrong");

    AST_READY_LOW: assert property (@(posedge core_clk) disable iff (!rst_n)
        !instr_ready |-> nop_cycle && pc_load)
        else $error("ready low outside branch no-op");

    AST_FLUSH_DROPS: assert property (@(posedge core_clk) disable iff (!rst_n)
        nop_cycle |=> !dec.valid && !pc_load && !nop_cycle)
        else $error("word taken in no-op cycle");

endmodule

// ===== ifd_fetch_model.sv
// Fetch path model: offers instruction words and their addresses.
// Assumes the decoder takes a word at a rising edge with instr_ready high.
`timescale 1ns/1ps
module ifd_fetch_model (
    input  wire logic   core_clk,
    input  wire logic   instr_ready,
    output logic        instr_valid,
    output logic [15:0] instr_word,
    output logic [20:0] instr_pc
);
    initial begin
        instr_valid = 1'b0;
        instr_word  = 16'h5a5a;
        instr_pc    = 21'h0_0000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Word held until taken; released lines show the inverse, never a stale word
    task automatic offer(input logic [15:0] word, input logic [20:0] pc, input logic more);
        instr_valid <= 1'b1;
        instr_word  <= word;
        instr_pc    <= pc;
        do @(posedge core_clk); while (instr_ready !== 1'b1);
        if (!more) begin
            instr_valid <= 1'b0;
            instr_word  <= ~word;
            instr_pc    <= ~pc;
        end
    endtask
endmodule

// ===== tb.sv
// Self-checking bench of the instruction format decoder.
// Assumes the fetch model drives the word port; the bench drives flags and bank.
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic [15:0]             w;
        logic [3:0]              bank;
        ifd_pkg::ifd_format_type fmt;
        logic [11:0]             addr;
    } ifd_row_type;

    logic                    core_clk;
    logic                    rst_n;
    logic                    zero_flag;
    logic [3:0]              bank_select;
    logic                    instr_valid;
    logic [15:0]             instr_word;
    logic [20:0]             instr_pc;
    logic                    instr_ready;
    ifd_pkg::ifd_decode_type dec;
    logic                    pc_load;
    logic [20:0]             pc_value;
    logic                    nop_cycle;
    int                      fails;
    int                      comparisons;
    ifd_row_type             rows [10];

    ifd_fetch_model fetch (
        .core_clk    (core_clk),
        .instr_ready (instr_ready),
        .instr_valid (instr_valid),
        .instr_word  (instr_word),
        .instr_pc    (instr_pc)
    );

    ifd_decoder uut (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .instr_valid (instr_valid),
        .instr_word  (instr_word),
        .instr_pc    (instr_pc),
        .zero_flag   (zero_flag),
        .bank_select (bank_select),
        .instr_ready (instr_ready),
        .dec         (dec),
        .pc_load     (pc_load),
        .pc_value    (pc_value),
        .nop_cycle   (nop_cycle)
    );

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic check(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            fails++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Two-word instruction, gap of idle cycles between the words
    task automatic two_word(input logic [15:0] w1, input logic [15:0] w2, input int gap);
        @(posedge core_clk);
        fetch.offer(w1, 21'h0_0040, gap == 0);
        repeat (gap) @(posedge core_clk);
        fetch.offer(w2, 21'h0_0042, 1'b0);
        @(negedge core_clk);
        check(dec.valid === 1'b1, "two-word valid");
    endtask

    task automatic branch(input logic [20:0] pc, input logic [7:0] n, input logic z);
        logic [20:0] tgt;
        tgt = pc + 21'h0_0002 + {{12{n[7]}}, n, 1'b0};
        @(posedge core_clk);
        zero_flag <= z;
        fetch.offer({8'he0, n}, pc, 1'b0);
        @(negedge core_clk);
        check(dec.valid === 1'b1 && dec.format === ifd_pkg::FMT_BRZ, "brz decode");
        check(pc_load === z && nop_cycle === z, "brz flow");
        check(instr_ready === !z, "brz ready in no-op");
        if (z) begin
            check(pc_value === tgt, "brz target");
            @(negedge core_clk);
            check(instr_ready === 1'b1 && nop_cycle === 1'b0, "no-op ends");
            check(pc_load === 1'b0 && dec.valid === 1'b0, "pulses one cycle");
        end else begin
            check(dec.target === tgt, "brz target not taken");
        end
        $display("branch pc %h n %h z %b done", pc, n, z);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge core_clk);
        fails++;
        test_done();
    end

    initial begin
        fails       = 0;
        comparisons = 0;
        rst_n       = 1'b0;
        zero_flag   = 1'b0;
        bank_select = 4'h0;
        rows[0] = '{16'h2405, 4'h3, ifd_pkg::FMT_BYTE, 12'h005};
        rows[1] = '{16'h2765, 4'h3, ifd_pkg::FMT_BYTE, 12'h365};
        rows[2] = '{16'h2670, 4'h3, ifd_pkg::FMT_BYTE, 12'hf70};
        rows[3] = '{16'h2560, 4'ha, ifd_pkg::FMT_BYTE, 12'ha60};
        rows[4] = '{16'h2c5f, 4'ha, ifd_pkg::FMT_BYTE, 12'h05f};
        rows[5] = '{16'h8e33, 4'h5, ifd_pkg::FMT_BIT,  12'h033};
        rows[6] = '{16'hb1a2, 4'h5, ifd_pkg::FMT_BIT,  12'h5a2};
        rows[7] = '{16'h0e7f, 4'h5, ifd_pkg::FMT_LIT,  12'h000};
        rows[8] = '{16'h0f80, 4'h5, ifd_pkg::FMT_LIT,  12'h000};
        rows[9] = '{16'hf123, 4'h5, ifd_pkg::FMT_NONE, 12'h523};
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        check(instr_ready === 1'b1 && dec === '0, "reset ready and dec");
        check(pc_load === 1'b0 && pc_value === 21'h0_0000 && nop_cycle === 1'b0, "reset pc");
        $display("reset test done");

        // Table of one-word formats
        foreach (rows[i]) begin
            @(posedge core_clk);
            bank_select <= rows[i].bank;
            fetch.offer(rows[i].w, 21'h0_0010, 1'b0);
            @(negedge core_clk);
            check(dec.valid === 1'b1 && dec.format === rows[i].fmt, "row format");
            if (rows[i].fmt == ifd_pkg::FMT_BYTE) begin
                check(dec.opcode === rows[i].w[15:10], "row opcode");
                check(dec.write_file === rows[i].w[9], "row write file");
                check(dec.write_working === ~rows[i].w[9], "row write working");
            end
            if (rows[i].fmt == ifd_pkg::FMT_BIT) begin
                check(dec.bit_pos === rows[i].w[11:9], "row bit position");
            end
            if (rows[i].fmt == ifd_pkg::FMT_LIT) begin
                check(dec.literal === rows[i].w[7:0], "row literal");
            end else begin
                check(dec.data_addr === rows[i].addr, "row address");
            end
        end
        $display("table test done");

        two_word(16'hc123, 16'hf456, 0);
        check(dec.format === ifd_pkg::FMT_MOVE, "move format");
        check(dec.move_src === 12'h123 && dec.move_dst === 12'h456, "move fields");
        $display("move test done");

        two_word(16'hef34, 16'hf125, 3);
        check(dec.format === ifd_pkg::FMT_GOTO && pc_load === 1'b1, "goto load");
        check(pc_value === 21'h2_4a68 && dec.target === 21'h2_4a68, "goto target");
        $display("goto test done");

        two_word(16'hed78, 16'hf00a, 0);
        check(dec.format === ifd_pkg::FMT_CALL && dec.fast_return === 1'b1, "call fast");
        check(pc_value === 21'h0_14f0, "call target");
        two_word(16'hec01, 16'hfabc, 1);
        check(dec.fast_return === 1'b0 && pc_value === 21'h15_7802, "call no fast");
        $display("call test done");

        two_word(16'hef00, 16'h1234, 1);
        check(dec.bad_second === 1'b1 && pc_load === 1'b0, "untagged second word");
        $display("bad second word test done");

        branch(21'h0_0100, 8'hfe, 1'b1);
        branch(21'h0_0200, 8'h7f, 1'b1);
        branch(21'h0_0200, 8'h80, 1'b1);
        branch(21'h0_0300, 8'h7f, 1'b0);
        branch(21'h0_0300, 8'h80, 1'b0);

        // Reset between the two words of a goto
        @(posedge core_clk);
        fetch.offer(16'hef12, 21'h0_0050, 1'b0);
        rst_n <= 1'b0;
        @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        check(instr_ready === 1'b1 && dec === '0 && pc_load === 1'b0, "mid-run reset");
        @(posedge core_clk);
        fetch.offer(16'h2405, 21'h0_0010, 1'b0);
        @(negedge core_clk);
        check(dec.valid === 1'b1 && dec.format === ifd_pkg::FMT_BYTE, "word after reset");
        $display("mid-run reset test done");
        test_done();
    end
endmodule
